// ### src/bfhs_sequencer.sv
// bfhs_sequencer: fault sequencer of a synchronous buck controller
// assumes comparator flags are synchronous to CORE_CLK and that
// CYCLE_STROBE pulses for one clock once per switching cycle
`timescale 1ns/1ns
`default_nettype none
module bfhs_sequencer
	import bfhs_pkg::*;
#(
	parameter int COOL_CYCLES = COOL_CYCLES_DEF,
	parameter int DW = 8
)
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	// switching cycle and high-side timing
	input wire logic CYCLE_STROBE,
	input wire logic HS_ON,
	// comparators
	input wire logic HS_OC,
	input wire logic LS_OC,
	input wire logic COMP_HIGH,
	input wire logic SD_LOW,
	input wire logic OT_HOT,
	// duty clamp
	input wire logic [DW-1:0] VOUT_CODE,
	input wire logic [DW-1:0] VIN_CODE,
	input wire logic [DW-1:0] DUTY_REQ,
	output logic [DW-1:0] DUTY_CMD,
	// drives and status
	output logic HS_GATE_EN,
	output logic LS_GATE_EN,
	output logic DISCHARGE_EN,
	output logic SOFT_START_ACTIVE,
	output logic HICCUP_ACTIVE
);

	localparam int CW = $clog2(COOL_CYCLES);
	localparam logic [CW-1:0] COOL_LAST = CW'(COOL_CYCLES - 1);
	localparam int NW = 2 * DW + 8;
	localparam logic [DW-1:0] FULL = {DW{1'b1}};

	bfhs_state_t state_r;
	bfhs_state_t state_nxt;
	logic [CW-1:0] cool_r;
	logic [CW-1:0] cool_nxt;
	logic [8:0] ss_r;
	logic [8:0] ss_nxt;
	logic [3:0] skip_cnt_r;
	logic [3:0] skip_cnt_nxt;
	logic [2:0] blank_r;
	logic [2:0] blank_nxt;
	logic ls_seen_r;
	logic ls_seen_nxt;
	logic skip_r;
	logic skip_nxt;
	logic clamp_r;
	logic clamp_nxt;
	logic hs_en_r;
	logic ls_en_r;
	logic dis_r;
	logic [DW-1:0] duty_r;
	logic [DW-1:0] duty_nxt;

	////////////////////////////////////////////////////////////////////////
	// fault detection

	// blanking counter restarts at every high-side turn-on
	// blanking window
	assign blank_nxt = !HS_ON ? 3'h0 :
		(blank_r == BLANK_CNT_MAX) ? blank_r : blank_r + 3'h1;

	wire blank_done = blank_r == BLANK_CNT_MAX;
	wire hs_trip = HS_ON && HS_OC && blank_done;
	wire driving = (state_r == ST_SOFT) || (state_r == ST_RUN);

	// low-side limit seen anywhere in the cycle skips the next high pulse
	// skip in soft start
	wire ls_any = ls_seen_r || LS_OC;
	assign ls_seen_nxt = CYCLE_STROBE ? 1'b0 : ls_any;
	assign skip_nxt = !driving ? 1'b0 : (CYCLE_STROBE ? ls_any : skip_r);
	assign clamp_nxt = !driving ? 1'b0 : (CYCLE_STROBE ? skip_r : clamp_r);

	// skip counter, cleared on shutdown entry
	assign skip_cnt_nxt = (state_r != ST_RUN || !COMP_HIGH || OT_HOT || SD_LOW) ? 4'h0 :
		!CYCLE_STROBE ? skip_cnt_r :
		skip_r ? skip_cnt_r + 4'h1 : 4'h0;

	wire skip_trip = (state_r == ST_RUN) && CYCLE_STROBE && COMP_HIGH &&
		skip_r && (skip_cnt_r == SKIP_LAST);

	////////////////////////////////////////////////////////////////////////
	// cycle counters

	// cool-down count, cleared on shutdown entry
	assign cool_nxt = (state_r != ST_HICCUP || OT_HOT || SD_LOW) ? '0 :
		CYCLE_STROBE ? cool_r + 1'b1 : cool_r;
	wire cool_done = CYCLE_STROBE && (cool_r == COOL_LAST);

	assign ss_nxt = (state_r != ST_SOFT) ? 9'h0 :
		CYCLE_STROBE ? ss_r + 9'h1 : ss_r;
	wire ss_done = CYCLE_STROBE && (ss_r == SS_LAST);

	////////////////////////////////////////////////////////////////////////
	// state machine

	always_comb
	begin
		state_nxt = state_r;
		if (OT_HOT)
			state_nxt = ST_THERM;
		else if (SD_LOW)
			state_nxt = ST_SHDN;
		else
		begin
			case (state_r)
				ST_SOFT:
				begin
					if (hs_trip)
						state_nxt = ST_HICCUP;
					else if (ss_done)
						state_nxt = ST_RUN;
				end
				ST_RUN:
				begin
					if (hs_trip || skip_trip)
						state_nxt = ST_HICCUP;
				end
				ST_HICCUP:
				begin
					if (cool_done)
						state_nxt = ST_SOFT;
				end
				default:
					state_nxt = ST_SOFT;
			endcase
		end
	end

	wire drive_nxt = (state_nxt == ST_SOFT) || (state_nxt == ST_RUN);
	wire off_nxt = (state_nxt == ST_SHDN) || (state_nxt == ST_THERM);

	////////////////////////////////////////////////////////////////////////
	// duty clamp

	wire [NW-1:0] clamp_num = NW'(VOUT_CODE) * NW'(FULL) * NW'(CLAMP_MUL);
	wire [NW-1:0] clamp_den = NW'(VIN_CODE) * NW'(CLAMP_DIV);
	wire [NW-1:0] clamp_quo = (clamp_den == '0) ? NW'(FULL) : clamp_num / clamp_den;
	wire [DW-1:0] clamp_val = (clamp_quo > NW'(FULL)) ? FULL : clamp_quo[DW-1:0];

	assign duty_nxt = !drive_nxt ? '0 :
		(clamp_nxt && DUTY_REQ > clamp_val) ? clamp_val : DUTY_REQ;

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
		begin
			state_r <= ST_SOFT;
			cool_r <= '0;
			ss_r <= 9'h0;
			skip_cnt_r <= 4'h0;
			blank_r <= 3'h0;
			ls_seen_r <= 1'b0;
			skip_r <= 1'b0;
			clamp_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cool_r <= cool_nxt;
			ss_r <= ss_nxt;
			skip_cnt_r <= skip_cnt_nxt;
			blank_r <= blank_nxt;
			ls_seen_r <= ls_seen_nxt;
			skip_r <= skip_nxt;
			clamp_r <= clamp_nxt;
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RESET_N)
		begin
			hs_en_r <= 1'b0;
			ls_en_r <= 1'b0;
			dis_r <= 1'b0;
			duty_r <= '0;
		end
		else
		begin
			hs_en_r <= drive_nxt && !skip_nxt;
			ls_en_r <= drive_nxt;
			dis_r <= off_nxt;
			duty_r <= duty_nxt;
		end
	end

	assign HS_GATE_EN = hs_en_r;
	assign LS_GATE_EN = ls_en_r;
	assign DISCHARGE_EN = dis_r;
	assign DUTY_CMD = duty_r;
	assign SOFT_START_ACTIVE = state_r == ST_SOFT;
	assign HICCUP_ACTIVE = state_r == ST_HICCUP;

	////////////////////////////////////////////////////////////////////////
	// assertions

	wire no_fault = !OT_HOT && !SD_LOW;

	hiccup_gates_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		state_r == ST_HICCUP |-> !HS_GATE_EN && !LS_GATE_EN)
		else $error("gate drive on during hiccup");

	cool_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		state_r == ST_HICCUP && no_fault && !cool_done |=> state_r == ST_HICCUP)
		else $error("hiccup left before cool-down end");

	cool_exit_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		state_r == ST_HICCUP && no_fault && cool_done |=> state_r == ST_SOFT && ss_r == 9'h0)
		else $error("no soft start after cool-down");

	ss_end_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		state_r == ST_SOFT && no_fault && !hs_trip && ss_done |=> state_r == ST_RUN)
		else $error("soft start did not finish at 400 cycles");

	ss_no_ls_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		state_r == ST_SOFT && !hs_trip |=> state_r != ST_HICCUP)
		else $error("hiccup from soft start without high-side trip");

	ss_skip_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		state_r == ST_SOFT && no_fault && CYCLE_STROBE && ls_any && !hs_trip && !ss_done
		|=> !HS_GATE_EN && LS_GATE_EN)
		else $error("low-side limit did not skip in soft start");

	skip_trip_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		state_r == ST_RUN && no_fault && skip_trip |=> state_r == ST_HICCUP)
		else $error("no hiccup after 16 skips");

	duty_cap_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		clamp_nxt && drive_nxt |=> DUTY_CMD <= $past(clamp_val))
		else $error("duty above clamp after skip");

	shdn_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		SD_LOW |=> !HS_GATE_EN && !LS_GATE_EN && DISCHARGE_EN)
		else $error("shutdown did not stop drives");

	therm_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		OT_HOT |=> state_r == ST_THERM && DISCHARGE_EN && !LS_GATE_EN)
		else $error("thermal shutdown not applied");

	therm_exit_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		state_r == ST_THERM && no_fault |=> state_r == ST_SOFT ##1 SOFT_START_ACTIVE || !no_fault)
		else $error("no soft start after thermal release");

	skip_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		!COMP_HIGH |=> skip_cnt_r == 4'h0)
		else $error("skip counter kept with node low");

	blank_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		$rose(HS_ON) |-> !hs_trip [*5])
		else $error("high-side trip inside blanking");

	hs_trip_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		driving && no_fault && hs_trip |=> HICCUP_ACTIVE && !HS_GATE_EN)
		else $error("high-side trip did not enter hiccup");

	off_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
		state_r == ST_SHDN || state_r == ST_THERM |-> cool_r == '0 && skip_cnt_r == 4'h0)
		else $error("counters kept in shutdown");

	hiccup_c: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
		state_r == ST_RUN ##1 state_r == ST_HICCUP);
	restart_c: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
		state_r == ST_HICCUP ##1 state_r == ST_SOFT);
	skip16_c: cover property (@(posedge CORE_CLK) disable iff (!RESET_N) skip_trip);
	therm_c: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
		state_r == ST_THERM ##1 state_r == ST_SOFT);

endmodule
`default_nettype wire

// ### src/bfhs_pkg.sv
// bfhs_pkg: constants and state type of the buck fault / hiccup sequencer
// assumes a 25 MHz core clock and a one-clock switching-cycle strobe
package bfhs_pkg;

	// core clock period
	localparam int CLK_PERIOD_NS = 40;
	// high-side current-limit blanking after turn-on (least time, round up)
	localparam int BLANK_NS = 200;
	localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] BLANK_CNT_MAX = 3'(BLANK_CYC);

	// switching-cycle counts
	localparam int COOL_CYCLES_DEF = 4096;
	localparam int SS_CYCLES = 400;
	localparam logic [8:0] SS_LAST = 9'(SS_CYCLES - 1);
	localparam logic [3:0] SKIP_LAST = 4'hF;

	// duty clamp: D <= 16/5 * vout / vin, capped at full scale
	localparam int CLAMP_MUL = 16;
	localparam int CLAMP_DIV = 5;

	// states, gray along soft -> run -> hiccup
	typedef enum logic [2:0] {
		ST_SOFT = 3'h0,
		ST_RUN = 3'h1,
		ST_HICCUP = 3'h3,
		ST_SHDN = 3'h6,
		ST_THERM = 3'h4
	} bfhs_state_t;

endpackage

// ### bench/bfhs_fet_model.sv
// bfhs_fet_model: power stage and comparators around the sequencer
// assumes gate enables come from the sequencer; shorts are bench commands
`timescale 1ns/1ns
`default_nettype none
module bfhs_fet_model
(
	// clock
	input wire logic clk,
	// gate drives and fault commands
	input wire logic hs_gate_en,
	input wire logic ls_gate_en,
	input wire logic hs_short,
	input wire logic ls_short,
	// switching cycle and comparators
	output logic cycle_strobe,
	output logic hs_on,
	output logic hs_oc,
	output logic ls_oc
);
	logic [2:0] ph_r = 3'h0;

	// eight clocks per switching cycle
	always @(posedge clk)
		ph_r <= ph_r + 3'h1;
	assign cycle_strobe = (ph_r == 3'h7);
	assign hs_on = hs_gate_en && (ph_r != 3'h0);
	assign hs_oc = hs_short && hs_on && (ph_r == 3'h7);
	// low-side limit only while that fet conducts
	assign ls_oc = ls_short && ls_gate_en && (ph_r == 3'h3);
endmodule
`default_nettype wire

// ### bench/bfhs_sequencer_tb_top.sv
// bfhs_sequencer_tb_top: self-checking bench of the fault sequencer
// assumes bfhs_pkg and the fet model; cool-down shortened to 16 cycles
`timescale 1ns/1ns
`default_nettype none
module bfhs_sequencer_tb_top;
	import bfhs_pkg::*;
	localparam int COOL = 16;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic comp_high = 1'b0;
	logic sd_low = 1'b0;
	logic ot_hot = 1'b0;
	logic hs_short = 1'b0;
	logic ls_short = 1'b0;
	logic [7:0] vout = 8'h00;
	logic [7:0] vin = 8'h01;
	logic [7:0] dreq = 8'h00;
	wire logic strobe, hs_on, hs_oc, ls_oc, hs_en, ls_en, dis_en, ss_act, hic_act;
	wire logic [7:0] dcmd;
	int mismatches = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	int k;
	int e;

	initial
	begin
		forever #20 clk = ~clk;
	end

	bfhs_sequencer #(.COOL_CYCLES(COOL)) uut
	(
		.CORE_CLK(clk), .RESET_N(rst_n), .CYCLE_STROBE(strobe), .HS_ON(hs_on),
		.HS_OC(hs_oc), .LS_OC(ls_oc), .COMP_HIGH(comp_high), .SD_LOW(sd_low),
		.OT_HOT(ot_hot), .VOUT_CODE(vout), .VIN_CODE(vin), .DUTY_REQ(dreq),
		.DUTY_CMD(dcmd), .HS_GATE_EN(hs_en), .LS_GATE_EN(ls_en),
		.DISCHARGE_EN(dis_en), .SOFT_START_ACTIVE(ss_act), .HICCUP_ACTIVE(hic_act)
	);

	bfhs_fet_model fet
	(
		.clk(clk), .hs_gate_en(hs_en), .ls_gate_en(ls_en), .hs_short(hs_short),
		.ls_short(ls_short), .cycle_strobe(strobe), .hs_on(hs_on), .hs_oc(hs_oc),
		.ls_oc(ls_oc)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic ended(input string s);
		$display("test %s done", s);
	endtask

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			mismatches++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		n = $urandom(32'h733e);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1 chk(16'({hs_en, ls_en, dis_en, ss_act}), 16'h000D);
		ended("power-on");
		// soft start under low-side limit
		n = 0;
		k = 0;
		e = 0;
		while (ss_act === 1'b1 && n < 500)
		begin
			@(posedge clk iff strobe);
			ls_short <= (n < 390);
			#1 n++;
			k += (hic_act !== 1'b0);
			e += (hs_en === 1'b0);
		end
		chk(16'(n), 16'h190);
		chk(16'(k), 16'h0);
		chk(16'(e > 0), 16'h1);
		ended("soft start");
		// skipped pulse then clamped duty, random voltages
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk iff strobe);
			// first pass forces a clamp well under the request
			vout <= (i == 0) ? 8'h01 : 8'($urandom);
			vin <= (i == 0) ? 8'h40 : 8'($urandom_range(255, 1));
			dreq <= (i == 0) ? 8'hFF : 8'($urandom);
			ls_short <= 1'b1;
			@(posedge clk iff strobe);
			ls_short <= 1'b0;
			#1 chk(16'(hs_en), 16'h0);
			e = 16 * 255 * int'(vout) / (5 * int'(vin));
			e = (e > 255) ? 255 : e;
			e = (int'(dreq) < e) ? int'(dreq) : e;
			@(posedge clk iff strobe);
			repeat (3) @(posedge clk);
			#1 chk(16'(dcmd), 16'(e));
		end
		ended("duty clamp");
		// persistent limit, node dips under 2 V once
		@(posedge clk iff strobe);
		ls_short <= 1'b1;
		comp_high <= 1'b1;
		n = 0;
		while (hic_act !== 1'b1 && n < 40)
		begin
			@(posedge clk iff strobe);
			comp_high <= (n != 9);
			#1 n++;
		end
		chk(16'(n), 16'h1B);
		chk(16'({hs_en, ls_en}), 16'h0000);
		@(posedge clk);
		ls_short <= 1'b0;
		comp_high <= 1'b0;
		n = 0;
		while (hic_act === 1'b1 && n < 100)
		begin
			@(posedge clk iff strobe);
			#1 n++;
		end
		chk(16'(n), 16'(COOL));
		chk(16'({hs_en, ls_en, ss_act}), 16'h0007);
		ended("hiccup");
		// high-side short during soft start
		@(posedge clk);
		hs_short <= 1'b1;
		@(posedge clk iff hs_oc);
		#1 chk(16'({hic_act, ss_act, hs_en, ls_en}), 16'h0008);
		@(posedge clk);
		hs_short <= 1'b0;
		ended("high-side trip");
		// shutdown pin, then over-temperature
		for (int m = 0; m < 2; m++)
		begin
			@(posedge clk);
			sd_low <= (m == 0);
			ot_hot <= (m == 1);
			@(posedge clk);
			#1 chk(16'({hs_en, ls_en, dis_en, hic_act, ss_act}), 16'h0004);
			@(posedge clk);
			sd_low <= 1'b0;
			ot_hot <= 1'b0;
			@(posedge clk);
			#1 chk(16'({hs_en, ls_en, dis_en, ss_act}), 16'h000D);
		end
		ended("shutdown");
		conclude();
	end
endmodule
`default_nettype wire
